// ==== rtl/dlpb_loop_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
module dlpb_loop_ctrl #(
  parameter int PHASE_W      = 16,
  parameter int PHASE_LSB_PS = 100
) (
  // Clock and reset.
  input  wire logic                 i_ref_clk,
  input  wire logic                 i_rstn,
  // Register port from the serial interface.
  input  wire logic [7:0]           i_reg_addr,
  input  wire logic                 i_reg_wr,
  input  wire logic                 i_reg_rd,
  input  wire logic [7:0]           i_reg_wdata,
  output logic      [7:0]           o_reg_rdata,
  // Loop and reference status.
  input  wire logic                 i_locked,
  input  wire logic                 i_ref_lost,
  input  wire logic [PHASE_W-1:0]   i_phase_meas,
  input  wire logic                 i_phase_valid,
  // Loop settings and absorption results.
  output logic      [3:0]           o_bw_step,
  output logic      [2:0]           o_damping,
  output logic      [15:0]          o_xo_trim,
  output logic                      o_reselect_req,
  output logic                      o_holdover,
  output logic      [PHASE_W+3:0]   o_phase_offset
);
  import dlpb_pkg::*;

  // ---------------------------------------------------------------
  // Parameter check
  // ---------------------------------------------------------------
  if (PHASE_W < 8 || PHASE_W > 28)
  begin : g_bad_width
    $error("Phase width out of range.");
  end

  // ---------------------------------------------------------------
  // Decoding functions
  // ---------------------------------------------------------------
  // Out-of-range bandwidth codes are held at the widest step.
  function automatic logic [3:0] clamp_bw(input logic [3:0] code);
    clamp_bw = (code > BW_STEP_MAX) ? BW_STEP_MAX : code; // see R3
  endfunction

  // Damping factor allowed for a bandwidth step and selection code.
  function automatic dlpb_damp_e damp_map(input logic [3:0] bw, input logic [2:0] code);
    damp_map = DAMP_5;
    if (code == 3'h1 && bw >= BW_18HZ)
    begin
      damp_map = DAMP_1P2; // see R2
    end
    else if ((code == 3'h1 && bw == BW_8HZ) || (code == 3'h2 && bw >= BW_18HZ))
    begin
      damp_map = DAMP_2P5; // see R1, R2
    end
    else if ((code == 3'h4 && bw >= BW_35HZ) || (code == 3'h5 && bw == BW_35HZ))
    begin
      damp_map = DAMP_10; // see R2
    end
    else if (code == 3'h5 && bw == BW_STEP_MAX)
    begin
      damp_map = DAMP_20; // see R2
    end
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [2:0]  damp_code_reg, damp_code_next;
  logic        auto_bw_reg, auto_bw_next;
  logic [3:0]  lock_bw_reg, lock_bw_next;
  logic [3:0]  acq_bw_reg, acq_bw_next;
  logic [7:0]  stage_lo_reg, stage_lo_next;
  logic [7:0]  stage_hi_reg, stage_hi_next;
  logic        lo_seen_reg, lo_seen_next;
  logic        hi_seen_reg, hi_seen_next;
  logic [15:0] trim_reg, trim_next;
  logic        psa_en_reg, psa_en_next;
  logic        psa_frz_reg, psa_frz_next;
  logic        en_prev_reg, en_prev_next;
  logic        trig_reg, trig_next;
  logic        resel_reg, resel_next;
  logic [3:0]  bw_reg, bw_next;
  logic [2:0]  damp_reg, damp_next;
  logic [7:0]  rdata_reg, rdata_next;
  logic        wr_lo, wr_hi;
  logic [3:0]  bw_active;

  dlpb_psa_if #(.PHASE_W(PHASE_W)) psa ();

  // Register writes, trim staging and absorption control.
  always_comb
  begin
    damp_code_next = damp_code_reg;
    auto_bw_next   = auto_bw_reg;
    lock_bw_next   = lock_bw_reg;
    acq_bw_next    = acq_bw_reg;
    stage_lo_next  = stage_lo_reg;
    stage_hi_next  = stage_hi_reg;
    lo_seen_next   = lo_seen_reg;
    hi_seen_next   = hi_seen_reg;
    trim_next      = trim_reg;
    psa_en_next    = psa_en_reg;
    psa_frz_next   = psa_frz_reg;
    wr_lo          = i_reg_wr && (i_reg_addr == REG_XO_TRIM_LO);
    wr_hi          = i_reg_wr && (i_reg_addr == REG_XO_TRIM_HI);
    if (i_reg_wr)
    begin
      case (i_reg_addr)
        REG_DAMPING:   damp_code_next = i_reg_wdata[2:0];
        REG_AUTO_BW:   auto_bw_next   = i_reg_wdata[AUTO_BW_EN_BIT];
        REG_LOCKED_BW: lock_bw_next   = i_reg_wdata[3:0];
        REG_ACQ_BW:    acq_bw_next    = i_reg_wdata[3:0];
        REG_PSA_CTRL:
        begin
          psa_en_next  = i_reg_wdata[PSA_EN_BIT];
          psa_frz_next = i_reg_wdata[PSA_FREEZE_BIT] & i_reg_wdata[PSA_EN_BIT]; // see R11
        end
        default:
        begin
          psa_en_next = psa_en_reg;
        end
      endcase
    end
    // The trim value is taken from two byte locations, committed as one word.
    if (wr_lo)
    begin
      stage_lo_next = i_reg_wdata; // see R6
      lo_seen_next  = 1'b1;
    end
    if (wr_hi)
    begin
      stage_hi_next = i_reg_wdata; // see R6
      hi_seen_next  = 1'b1;
    end
    if (lo_seen_next && hi_seen_next)
    begin
      trim_next    = {stage_hi_next, stage_lo_next}; // see R15
      lo_seen_next = 1'b0;
      hi_seen_next = 1'b0;
    end
    en_prev_next = psa_en_reg;
    // Reference loss, or enabling while locked, raises the absorption trigger.
    trig_next  = i_ref_lost || (psa_en_reg && !en_prev_reg && i_locked); // see R8, R13
    resel_next = i_ref_lost; // see R8
  end

  // Bandwidth, damping and read data.
  always_comb
  begin
    if (auto_bw_reg && !i_locked)
    begin
      bw_active = clamp_bw(acq_bw_reg); // see R4
    end
    else
    begin
      bw_active = clamp_bw(lock_bw_reg); // see R4, R14
    end
    bw_next    = bw_active;
    damp_next  = damp_map(bw_active, damp_code_reg); // see R1, R2
    rdata_next = rdata_reg;
    if (i_reg_rd)
    begin
      case (i_reg_addr)
        REG_DAMPING:     rdata_next = {5'h00, damp_code_reg};
        REG_AUTO_BW:     rdata_next = {7'h00, auto_bw_reg};
        REG_LOCKED_BW:   rdata_next = {4'h0, lock_bw_reg};
        REG_ACQ_BW:      rdata_next = {4'h0, acq_bw_reg};
        REG_XO_TRIM_LO:  rdata_next = trim_reg[7:0];
        REG_XO_TRIM_HI:  rdata_next = trim_reg[15:8];
        REG_PSA_CTRL:    rdata_next = {4'h0, psa_frz_reg, psa_en_reg, 2'h0};
        REG_LOOP_STATUS: rdata_next = {1'b0, psa.busy, psa.holdover, i_locked, bw_reg};
        default:         rdata_next = 8'h00;
      endcase
    end
  end

  // Register all control state.
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rstn)
    begin
      damp_code_reg <= DAMPING_RST;
      auto_bw_reg   <= 1'b0;
      lock_bw_reg   <= LOCKED_BW_RST;
      acq_bw_reg    <= ACQ_BW_RST;
      stage_lo_reg  <= XO_TRIM_RST[7:0];
      stage_hi_reg  <= XO_TRIM_RST[15:8];
      lo_seen_reg   <= 1'b0;
      hi_seen_reg   <= 1'b0;
      trim_reg      <= XO_TRIM_RST; // see R7
      psa_en_reg    <= 1'b1;        // see R11
      psa_frz_reg   <= 1'b0;
      en_prev_reg   <= 1'b1;
      trig_reg      <= 1'b0;
      resel_reg     <= 1'b0;
      bw_reg        <= LOCKED_BW_RST;
      damp_reg      <= DAMP_5;
      rdata_reg     <= 8'h00;
    end
    else
    begin
      damp_code_reg <= damp_code_next;
      auto_bw_reg   <= auto_bw_next;
      lock_bw_reg   <= lock_bw_next;
      acq_bw_reg    <= acq_bw_next;
      stage_lo_reg  <= stage_lo_next;
      stage_hi_reg  <= stage_hi_next;
      lo_seen_reg   <= lo_seen_next;
      hi_seen_reg   <= hi_seen_next;
      trim_reg      <= trim_next;
      psa_en_reg    <= psa_en_next;
      psa_frz_reg   <= psa_frz_next;
      en_prev_reg   <= en_prev_next;
      trig_reg      <= trig_next;
      resel_reg     <= resel_next;
      bw_reg        <= bw_next;
      damp_reg      <= damp_next;
      rdata_reg     <= rdata_next;
    end
  end

  // Drive the absorption engine.
  assign psa.trigger     = trig_reg;
  assign psa.enable      = psa_en_reg;
  assign psa.freeze      = psa_frz_reg; // see R12
  assign psa.phase_meas  = i_phase_meas;
  assign psa.phase_valid = i_phase_valid;

  dlpb_psa_engine #(
    .PHASE_W      (PHASE_W),
    .PHASE_LSB_PS (PHASE_LSB_PS)
  ) u_engine (
    .i_ref_clk (i_ref_clk),
    .i_rstn    (i_rstn),
    .psa       (psa.eng)
  );

  // Outputs from flip-flops.
  assign o_reg_rdata    = rdata_reg;
  assign o_bw_step      = bw_reg;
  assign o_damping      = damp_reg;
  assign o_xo_trim      = trim_reg;
  assign o_reselect_req = resel_reg;
  assign o_holdover     = psa.holdover;
  assign o_phase_offset = psa.offset;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);

  property p_damp_low;
    (bw_active <= BW_4HZ) |=> (o_damping == DAMP_5);
  endproperty
  a_damp_low: assert property (p_damp_low) // see R1
    else $error("Low bandwidth damping is not 5.");

  property p_damp_top;
    (bw_active == BW_STEP_MAX && damp_code_reg == 3'h5) |=> (o_damping == DAMP_20);
  endproperty
  a_damp_top: assert property (p_damp_top) // see R2
    else $error("Top bandwidth code 5 is not damping 20.");

  property p_bw_range;
    o_bw_step <= BW_STEP_MAX;
  endproperty
  a_bw_range: assert property (p_bw_range) // see R3
    else $error("Bandwidth step beyond the tenth.");

  property p_auto_acq;
    (auto_bw_reg && !i_locked) |=> (o_bw_step == clamp_bw($past(acq_bw_reg)));
  endproperty
  a_auto_acq: assert property (p_auto_acq) // see R4
    else $error("Acquisition bandwidth not used while unlocked.");

  property p_manual_bw;
    !auto_bw_reg |=> (o_bw_step == clamp_bw($past(lock_bw_reg)));
  endproperty
  a_manual_bw: assert property (p_manual_bw) // see R14
    else $error("Locked bandwidth not used in manual mode.");

  property p_trim_reset;
    $rose(i_rstn) |-> (o_xo_trim == XO_TRIM_RST);
  endproperty
  a_trim_reset: assert property (p_trim_reset) // see R7
    else $error("Trim not at zero-offset value after reset.");

  property p_trim_half;
    (wr_lo && !hi_seen_reg && !wr_hi) |=> $stable(o_xo_trim);
  endproperty
  a_trim_half: assert property (p_trim_half) // see R15
    else $error("Trim changed after a single byte.");

  property p_ref_lost;
    i_ref_lost |=> (o_reselect_req && trig_reg);
  endproperty
  a_ref_lost: assert property (p_ref_lost) // see R8
    else $error("Reference loss did not request reselection.");

  property p_enable_trig;
    (psa_en_reg && !en_prev_reg && i_locked) |=> trig_reg;
  endproperty
  a_enable_trig: assert property (p_enable_trig) // see R13
    else $error("Enabling while locked did not trigger.");

  c_trim_commit: cover property (wr_hi ##[1:20] wr_lo);
  c_auto_switch: cover property (auto_bw_reg && !i_locked ##1 i_locked);
  c_damp_20:     cover property (o_damping == DAMP_20);

endmodule
`default_nettype wire

// ==== inc/dlpb_pkg.sv ====
// Summary of operation
// R1: Damping code maps to 5 below 8 Hz; at 8 Hz code 1 gives 2.5.
// R2: At 18/35/70 Hz codes 1..3 give 1.2/2.5/5; codes 4,5 rise with bandwidth.
// R3: Loop bandwidth is one of ten steps from 0.1 Hz to 70 Hz.
// R4: Wide acquisition bandwidth while unlocked, narrow locked bandwidth once locked.
// R5: The system supplies a 12.800 MHz master oscillator.
// R6: Two trim bytes form one unsigned value; each step adds 0.0196229 ppm.
// R7: Trim resets to 39321 (zero offset); full range spans -771 to +514 ppm.
// R8: Loss of the selected reference requests reselection and triggers phase absorption.
// R9: Absorption holds over, measures new input phase, then adds a compensating offset.
// R10: The output phase step after absorption stays within 5 ns.
// R11: Absorption can be enabled, disabled or frozen; enabled after reset, freeze needs enable.
// R12: While frozen, later events are ignored and the held offset is kept.
// R13: Enabling absorption while locked triggers an absorption event.
// R14: Without automatic selection only the locked bandwidth is used.
// R15: A new trim value is applied only after both bytes are written.
`default_nettype none
package dlpb_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_LOOP_STATUS = 8'h09;
  localparam logic [7:0] REG_AUTO_BW     = 8'h3B;
  localparam logic [7:0] REG_XO_TRIM_LO  = 8'h3C;
  localparam logic [7:0] REG_XO_TRIM_HI  = 8'h3D;
  localparam logic [7:0] REG_PSA_CTRL    = 8'h48;
  localparam logic [7:0] REG_LOCKED_BW   = 8'h67;
  localparam logic [7:0] REG_ACQ_BW      = 8'h69;
  localparam logic [7:0] REG_DAMPING     = 8'h6B;

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int          AUTO_BW_EN_BIT = 0;
  localparam int          PSA_EN_BIT     = 2;
  localparam int          PSA_FREEZE_BIT = 3;
  localparam logic [15:0] XO_TRIM_RST    = 16'h9999;
  localparam logic [2:0]  DAMPING_RST    = 3'h3;
  localparam logic [3:0]  LOCKED_BW_RST  = 4'h3;
  localparam logic [3:0]  ACQ_BW_RST     = 4'h6;

  // ---------------------------------------------------------------
  // Bandwidth steps: 0.1 0.3 0.6 1.2 2.5 4 8 18 35 70 Hz
  // ---------------------------------------------------------------
  localparam logic [3:0] BW_4HZ      = 4'h5;
  localparam logic [3:0] BW_8HZ      = 4'h6;
  localparam logic [3:0] BW_18HZ     = 4'h7;
  localparam logic [3:0] BW_35HZ     = 4'h8;
  localparam logic [3:0] BW_STEP_MAX = 4'h9;

  // ---------------------------------------------------------------
  // Physical figures
  // ---------------------------------------------------------------
  localparam real XO_NOMINAL_MHZ   = 12.800;
  localparam real XO_TRIM_STEP_PPM = 0.0196229;
  localparam int  PSA_MAX_STEP_PS  = 5000;

  // Damping factor selections.
  typedef enum logic [2:0] {
    DAMP_1P2 = 3'h0,
    DAMP_2P5 = 3'h1,
    DAMP_5   = 3'h2,
    DAMP_10  = 3'h3,
    DAMP_20  = 3'h4
  } dlpb_damp_e;

  // Phase absorption engine states.
  typedef enum logic [3:0] {
    PSA_IDLE  = 4'h1,
    PSA_HOLD  = 4'h2,
    PSA_MEAS  = 4'h4,
    PSA_APPLY = 4'h8
  } dlpb_psa_e;

endpackage
`default_nettype wire

// ==== inc/dlpb_pbo_if.sv ====
`timescale 1ns/1ps
`default_nettype none
// Control and result path between the loop controller and the absorption engine.
interface dlpb_psa_if #(
  parameter int PHASE_W = 16
);
  logic                 trigger;
  logic                 enable;
  logic                 freeze;
  logic [PHASE_W-1:0]   phase_meas;
  logic                 phase_valid;
  logic                 holdover;
  logic                 busy;
  logic [PHASE_W+3:0]   offset;

  modport ctl (output trigger, enable, freeze, phase_meas, phase_valid,
               input holdover, busy, offset);
  modport eng (input trigger, enable, freeze, phase_meas, phase_valid,
               output holdover, busy, offset);
endinterface
`default_nettype wire

// ==== rtl/dlpb_pbo_engine.sv ====
`timescale 1ns/1ps
`default_nettype none
module dlpb_psa_engine #(
  parameter int PHASE_W      = 16,
  parameter int PHASE_LSB_PS = 100
) (
  // Clock and reset.
  input  wire logic i_ref_clk,
  input  wire logic i_rstn,
  // Engine side of the absorption path.
  dlpb_psa_if.eng   psa
);
  import dlpb_pkg::*;

  // ---------------------------------------------------------------
  // Parameter check
  // ---------------------------------------------------------------
  // The whole measured step is absorbed, so the residual is below one
  // phase step, which must not exceed the allowed transient.
  if (PHASE_LSB_PS > PSA_MAX_STEP_PS || PHASE_LSB_PS < 1) // see R10
  begin : g_bad_lsb
    $error("Phase step too coarse for the allowed transient.");
  end

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  dlpb_psa_e          state_reg, state_next;
  logic               pend_reg, pend_next;
  logic               hold_reg, hold_next;
  logic               busy_reg, busy_next;
  logic [PHASE_W+3:0] ofs_reg, ofs_next;

  // Sequence: enter holdover, measure the new input, absorb the step.
  always_comb
  begin
    state_next = state_reg;
    pend_next  = pend_reg;
    ofs_next   = ofs_reg;
    case (state_reg)
      PSA_IDLE:
        if ((psa.trigger || pend_reg) && !psa.freeze) // see R12
        begin
          state_next = PSA_HOLD; // see R9
          pend_next  = 1'b0;
        end
      PSA_HOLD:
        state_next = PSA_MEAS;
      PSA_MEAS:
        if (psa.phase_valid)
        begin
          ofs_next   = ofs_reg + {{4{psa.phase_meas[PHASE_W-1]}}, psa.phase_meas}; // see R9, R10
          state_next = PSA_APPLY;
        end
      PSA_APPLY:
        state_next = PSA_IDLE;
      default:
        state_next = PSA_IDLE;
    endcase
    // A switch during a running absorption is remembered, not lost.
    if (psa.trigger && state_reg != PSA_IDLE)
    begin
      pend_next = 1'b1;
    end
    // Frozen engine drops pending work; disabled engine clears the offset.
    if (psa.freeze)
    begin
      pend_next = 1'b0; // see R12
    end
    if (!psa.enable)
    begin
      state_next = PSA_IDLE; // see R11
      pend_next  = 1'b0;
      ofs_next   = '0;
    end
    hold_next = (state_next == PSA_HOLD) || (state_next == PSA_MEAS);
    busy_next = (state_next != PSA_IDLE);
  end

  // Register the engine state.
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rstn)
    begin
      state_reg <= PSA_IDLE;
      pend_reg  <= 1'b0;
      hold_reg  <= 1'b0;
      busy_reg  <= 1'b0;
      ofs_reg   <= '0;
    end
    else
    begin
      state_reg <= state_next;
      pend_reg  <= pend_next;
      hold_reg  <= hold_next;
      busy_reg  <= busy_next;
      ofs_reg   <= ofs_next;
    end
  end

  // Results are presented from flip-flops.
  assign psa.holdover = hold_reg;
  assign psa.busy     = busy_reg;
  assign psa.offset   = ofs_reg;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);

  property p_psa_start;
    (state_reg == PSA_IDLE && psa.trigger && psa.enable && !psa.freeze)
      |=> (state_reg == PSA_HOLD) ##1 (state_reg == PSA_MEAS && hold_reg);
  endproperty
  a_psa_start: assert property (p_psa_start) // see R9
    else $error("Absorption did not enter holdover and measure.");

  property p_psa_absorb;
    (state_reg == PSA_MEAS && psa.phase_valid && psa.enable)
      |=> (ofs_reg == $past(ofs_reg) + {{4{$past(psa.phase_meas[PHASE_W-1])}},
                                          $past(psa.phase_meas)}) && !hold_reg;
  endproperty
  a_psa_absorb: assert property (p_psa_absorb) // see R10
    else $error("Measured phase step was not absorbed exactly.");

  property p_psa_frozen;
    (psa.freeze && psa.enable && state_reg == PSA_IDLE)
      |=> (state_reg == PSA_IDLE) && $stable(ofs_reg);
  endproperty
  a_psa_frozen: assert property (p_psa_frozen) // see R12
    else $error("Frozen absorption reacted to an event.");

  property p_psa_off;
    !psa.enable |=> (ofs_reg == '0) && !busy_reg;
  endproperty
  a_psa_off: assert property (p_psa_off) // see R11
    else $error("Disabled absorption kept an offset.");

  c_psa_apply: cover property (state_reg == PSA_MEAS && psa.phase_valid);
  c_psa_pend:  cover property (pend_reg && state_reg == PSA_APPLY);

endmodule
`default_nettype wire

// ==== tb/dlpb_ref_src.sv ====
`timescale 1ns/1ps
`default_nettype none
// Reference side: answers each holdover with one phase measurement after a set delay.
module dlpb_ref_src (
  // Clock and reset.
  input  wire logic        i_ref_clk,
  input  wire logic        i_rstn,
  // Holdover seen from the block and the answer to give.
  input  wire logic        i_holdover,
  input  wire logic [15:0] i_meas_val,
  input  wire logic [3:0]  i_meas_dly,
  // Measurement towards the block.
  output logic             o_phase_valid,
  output logic [15:0]      o_phase_meas
);
  logic [3:0] wait_reg;
  logic       sent_reg;

  // Counts holdover cycles and pulses once; outside the pulse and reset the data toggles every cycle.
  always_ff @(posedge i_ref_clk)
  begin
    o_phase_valid <= 1'b0;
    o_phase_meas  <= ~o_phase_meas;
    if (!i_rstn || !i_holdover)
    begin
      wait_reg <= 4'h0;
      sent_reg <= 1'b0;
      if (!i_rstn)
        o_phase_meas <= 16'hA5A5;
    end
    else if (wait_reg == i_meas_dly && !sent_reg)
    begin
      o_phase_valid <= 1'b1;
      o_phase_meas  <= i_meas_val;
      sent_reg      <= 1'b1;
    end
    else
      wait_reg <= wait_reg + 4'h1;
  end
endmodule
`default_nettype wire

// ==== tb/test_dpll_loop_phase_buildout.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin fails++; \
  $display("[ERR] %s expected %h seen %h", nm, ex, got); end end
module test_dpll_loop_phase_buildout;
  import dlpb_pkg::*;
  logic        clk, rstn, wr, rd, locked, lost, pvalid, resel, hold;
  logic [7:0]  addr, wdata, rdata;
  logic [15:0] pmeas, trim, mval;
  logic [3:0]  bw, mdly;
  logic [2:0]  damp;
  logic [19:0] offset, exp_off;
  int          fails, checks_done, cyc, n;

  dlpb_loop_ctrl i_dlpb_loop_ctrl (.i_ref_clk(clk), .i_rstn(rstn), .i_reg_addr(addr),
    .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
    .i_locked(locked), .i_ref_lost(lost), .i_phase_meas(pmeas), .i_phase_valid(pvalid),
    .o_bw_step(bw), .o_damping(damp), .o_xo_trim(trim), .o_reselect_req(resel),
    .o_holdover(hold), .o_phase_offset(offset));
  dlpb_ref_src i_dlpb_ref_src (.i_ref_clk(clk), .i_rstn(rstn), .i_holdover(hold),
    .i_meas_val(mval), .i_meas_dly(mdly), .o_phase_valid(pvalid), .o_phase_meas(pmeas));

  // ---------------------------------------------------------------
  // Clock, watchdog and tasks
  // ---------------------------------------------------------------
  // Free running 125 MHz clock.
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Cuts a hang short well above the expected run length.
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      close_out();
    end
  end

  task automatic close_out();
    if (fails == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Waits edges, then moves just past the last one so outputs have settled.
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    tick(1);
    addr  = a;
    wdata = d;
    wr    = 1'b1;
    tick(1);
    wr    = 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    tick(1);
    addr = a;
    rd   = 1'b1;
    tick(1);
    rd   = 1'b0;
    `CHK("rdata", e, rdata)
  endtask

  // Waits a bounded time for holdover to end, then checks the accumulated offset.
  task automatic settle(input logic [15:0] m);
    n = 0;
    while (hold === 1'b1 && n < 30)
    begin
      tick(1);
      n++;
    end
    `CHK("holdover", 1'b0, hold)
    exp_off = exp_off + {{4{m[15]}}, m};
    `CHK("offset", exp_off, offset)
  endtask

  task automatic absorb(input logic [15:0] m, input logic [3:0] d);
    mval = m;
    mdly = d;
    lost = 1'b1;
    tick(1);
    `CHK("reselect", 1'b1, resel)
    lost = 1'b0;
    tick(1);
    `CHK("reselect", 1'b0, resel)
    `CHK("holdover", 1'b1, hold)
    settle(m);
  endtask

  // Damping factor expected for a bandwidth step and a selection code.
  function automatic logic [2:0] damp_exp(input int b, input int c);
    if (c < 1 || c > 5 || b < 6)
      return DAMP_5;
    if (b == 6)
      return (c == 1) ? DAMP_2P5 : DAMP_5;
    if (c < 4)
      return 3'(c - 1);
    if (b == 7)
      return DAMP_5;
    return (b == 9 && c == 5) ? DAMP_20 : DAMP_10;
  endfunction

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  // Resets the block, then walks settings, trim and phase absorption.
  initial
  begin
    {rstn, wr, rd, locked, lost, addr, wdata, mval, mdly, exp_off} = '0;
    tick(2);
    rstn = 1'b1;
    `CHK("bw", 4'h3, bw)
    `CHK("damping", DAMP_5, damp)
    `CHK("trim", 16'h9999, trim)
    rd_chk(REG_DAMPING, 8'h03);
    rd_chk(REG_XO_TRIM_HI, 8'h99);
    rd_chk(REG_PSA_CTRL, 8'h04);
    rd_chk(8'hFF, 8'h00);
    for (int b = 0; b < 16; b++)
    begin
      wr_reg(REG_LOCKED_BW, 8'(b));
      for (int c = 0; c < 8; c++)
      begin
        wr_reg(REG_DAMPING, 8'(c));
        tick(1);
        `CHK("bw", 4'((b > 9) ? 9 : b), bw)
        `CHK("damping", damp_exp((b > 9) ? 9 : b, c), damp)
      end
    end
    wr_reg(REG_AUTO_BW, 8'h01);
    wr_reg(REG_LOCKED_BW, 8'h02);
    tick(1);
    `CHK("bw", ACQ_BW_RST, bw)
    wr_reg(REG_ACQ_BW, 8'h0C);
    tick(1);
    `CHK("bw", 4'h9, bw)
    rd_chk(REG_ACQ_BW, 8'h0C);
    locked = 1'b1;
    tick(2);
    `CHK("bw", 4'h2, bw)
    rd_chk(REG_LOOP_STATUS, 8'h12);
    locked = 1'b0;
    wr_reg(REG_AUTO_BW, 8'h00);
    tick(1);
    `CHK("bw", 4'h2, bw)
    wr_reg(REG_XO_TRIM_LO, 8'h9A);
    `CHK("trim", 16'h9999, trim)
    wr_reg(REG_XO_TRIM_HI, 8'h98);
    `CHK("trim", 16'h989A, trim)
    rd_chk(REG_XO_TRIM_LO, 8'h9A);
    wr_reg(REG_XO_TRIM_HI, 8'hFF);
    `CHK("trim", 16'h989A, trim)
    wr_reg(REG_XO_TRIM_LO, 8'hFF);
    `CHK("trim", 16'hFFFF, trim)
    absorb(16'h0123, 4'h0);
    absorb(16'hFF00, 4'h9);
    absorb(16'h7FFF, 4'h3);
    wr_reg(REG_PSA_CTRL, 8'h0C);
    lost = 1'b1;
    tick(1);
    lost = 1'b0;
    repeat (4)
    begin
      tick(1);
      `CHK("holdover", 1'b0, hold)
    end
    `CHK("offset", exp_off, offset)
    wr_reg(REG_PSA_CTRL, 8'h08);
    rd_chk(REG_PSA_CTRL, 8'h00);
    exp_off = '0;
    `CHK("offset", exp_off, offset)
    locked = 1'b1;
    mval = 16'h0040;
    mdly = 4'h2;
    wr_reg(REG_PSA_CTRL, 8'h04);
    n = 0;
    while (hold !== 1'b1 && n < 4)
    begin
      tick(1);
      n++;
    end
    `CHK("holdover", 1'b1, hold)
    settle(16'h0040);
    close_out();
  end
endmodule
`default_nettype wire
